// File: logic/hold_qualifier.sv
// Qualifies a held level: one pulse once the level has lasted past a limit
module hold_qualifier (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Level and limit
  input  wire logic        level,
  input  wire logic [31:0] limit,
  // Result
  output logic             fire
);

  logic [31:0] cnt_r;

  // -------------------------------------------------------------------------
  // Hold counter
  // -------------------------------------------------------------------------
  // Any gap clears the count, so only an unbroken hold qualifies
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 32'h0000_0000;
    end else if (!level) begin
      cnt_r <= 32'h0000_0000;
    end else if (cnt_r <= limit) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  // Pulse once per hold; count parks above the limit afterwards
  assign fire = level && (cnt_r == limit);

  a_hold_fire_count: assert property (@(posedge aclk) disable iff (!aresetn)
    fire |-> (cnt_r == limit) && level && ($past(level) || limit == 32'h0000_0000))
    else $error("hold fired without an unbroken hold");

  a_hold_gap_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    !level |=> (cnt_r == 32'h0000_0000) && !fire)
    else $error("hold count survived an open contact");

endmodule : hold_qualifier

// File: logic/reset_status_ctrl.sv
// Local, external and grand total reset plus state driven status output
module reset_status_ctrl #(
  parameter logic [31:0] LOC_HOLD_CYC  = reset_status_pkg::LOCAL_RESET_CYC,
  parameter logic [31:0] GT_HOLD_CYC   = reset_status_pkg::GRAND_CLEAR_CYC,
  parameter logic [31:0] EXT_SLOW_CYC  = reset_status_pkg::EXT_SLOW_CYC,
  parameter logic [31:0] EXT_FAST_CYC  = reset_status_pkg::EXT_FAST_CYC,
  parameter logic [31:0] SEC_CYC       = reset_status_pkg::SECOND_CYC
) (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Timer core
  input  wire reset_status_pkg::timer_state_t timer_state,
  input  wire logic                          display_mode,
  output logic                               timer_reset,
  // Front panel pins: [1:0] reset pair, [3:2] grand total pair
  input  wire logic [3:0]                    panel_btn,
  // External reset contact, high while the two reset terminals are joined
  input  wire logic                          ext_reset_closed,
  // Status output and display
  output logic                               status_oc_o,
  output logic                               status_oc_oe,
  output logic                               status_annunciator,
  output logic                               grand_total_view
);

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  reset_status_pkg::cfg_t  cfg_r;
  reset_status_pkg::stat_t stat_w;
  logic [14:0] delay_r;
  logic [4:0]  pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
  logic        loc_level, gt_level, ext_level;
  logic        loc_fire, gt_fire, ext_fire;
  logic        loc_reset, gt_clear;
  logic [31:0] ext_limit;
  logic        timer_reset_r, gt_view_r;
  logic [31:0] sec_cnt_r;
  logic        sec_tick;
  logic [31:0] grand_total_r;
  reset_status_pkg::timer_state_t prev_state_r;
  logic        entered, on_hit, off_hit;
  logic        status_r, pend_r, status_pin_r;
  logic [14:0] dly_sec_r;
  logic [31:0] dly_cyc_r;
  logic        aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r, rdata_nxt, ctrl_word, delay_word, wr_ctrl, wr_delay;
  logic [1:0]  rresp_nxt;
  logic        wr_go;

  // Byte lane merge of a write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  // Three stages; filtered level moves only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      pin_s3_r <= 5'h00;
      pin_f_r  <= 5'h00;
    end else begin
      pin_s1_r <= {ext_reset_closed, panel_btn};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r  <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
    end
  end

  // Button pairs only count while the display mode is shown
  assign loc_level = display_mode && pin_f_r[0] && pin_f_r[1];
  assign gt_level  = display_mode && pin_f_r[2] && pin_f_r[3];
  assign ext_level = pin_f_r[4];
  assign ext_limit = cfg_r.quick_reset_qualify ? EXT_FAST_CYC : EXT_SLOW_CYC;

  // -------------------------------------------------------------------------
  // Hold qualifiers
  // -------------------------------------------------------------------------
  hold_qualifier u_loc_hold (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (loc_level),
    .limit   (LOC_HOLD_CYC),
    .fire    (loc_fire)
  );

  hold_qualifier u_gt_hold (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (gt_level),
    .limit   (GT_HOLD_CYC),
    .fire    (gt_fire)
  );

  hold_qualifier u_ext_hold (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (ext_level),
    .limit   (ext_limit),
    .fire    (ext_fire)
  );

  assign loc_reset = loc_fire && cfg_r.local_timer_reset_enable;
  assign gt_clear  = gt_fire && cfg_r.grand_total_clear_enable;

  // -------------------------------------------------------------------------
  // Timer reset pulse and grand total view
  // -------------------------------------------------------------------------
  // Local and external sources merge into one registered pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_reset_r <= 1'b0;
      gt_view_r     <= 1'b0;
    end else begin
      timer_reset_r <= loc_reset || ext_fire;
      gt_view_r     <= gt_level;
    end
  end

  assign timer_reset      = timer_reset_r;
  assign grand_total_view = gt_view_r;

  a_loc_reset_src: assert property (@(posedge aclk) disable iff (!aresetn)
    loc_fire && cfg_r.local_timer_reset_enable |=> timer_reset)
    else $error("local hold did not reset the timer");

  a_ext_reset_src: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(timer_reset) |-> $past(ext_fire) || ($past(loc_fire)
      && $past(cfg_r.local_timer_reset_enable)))
    else $error("timer reset without a qualified source");

  a_ext_slow_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_fire && !cfg_r.quick_reset_qualify |-> ext_limit == EXT_SLOW_CYC)
    else $error("slow external reset used the wrong hold");

  a_ext_fast_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_fire && cfg_r.quick_reset_qualify |-> ext_limit == EXT_FAST_CYC)
    else $error("fast external reset used the wrong hold");

  // -------------------------------------------------------------------------
  // Grand total of run time
  // -------------------------------------------------------------------------
  // Free running second divider; a partial first second is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt_r <= 32'h0000_0000;
    end else if (sec_tick) begin
      sec_cnt_r <= 32'h0000_0000;
    end else begin
      sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
    end
  end

  assign sec_tick = (sec_cnt_r == SEC_CYC - 32'h0000_0001);

  // Clear wins over a counting second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grand_total_r <= 32'h0000_0000;
    end else if (gt_clear) begin
      grand_total_r <= 32'h0000_0000;
    end else if (sec_tick && timer_state == reset_status_pkg::ST_RUN) begin
      grand_total_r <= grand_total_r + 32'h0000_0001;
    end
  end

  a_total_counts: assert property (@(posedge aclk) disable iff (!aresetn)
    sec_tick && timer_state == reset_status_pkg::ST_RUN && !gt_clear
      |=> grand_total_r == $past(grand_total_r) + 32'h0000_0001)
    else $error("grand total missed a running second");

  a_total_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    gt_fire && cfg_r.grand_total_clear_enable |=> grand_total_r == 32'h0000_0000)
    else $error("grand total not cleared after the hold");

  // -------------------------------------------------------------------------
  // Status output state tracking
  // -------------------------------------------------------------------------
  // Only a change of state counts as an entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_state_r <= reset_status_pkg::ST_RESET;
    end else begin
      prev_state_r <= timer_state;
    end
  end

  assign entered = (timer_state != prev_state_r);
  assign on_hit  = cfg_r.on_inv ? (timer_state != cfg_r.on_state)
                                : (timer_state == cfg_r.on_state);
  assign off_hit = cfg_r.off_inv ? (timer_state != cfg_r.off_state)
                                 : (timer_state == cfg_r.off_state);

  // On entry the turn-on match wins over turn-off; a delay holds it back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r  <= 1'b0;
      pend_r    <= 1'b0;
      dly_sec_r <= 15'h0000;
      dly_cyc_r <= 32'h0000_0000;
    end else if (entered && on_hit) begin
      status_r  <= (delay_r == 15'h0000) ? 1'b1 : status_r;
      pend_r    <= (delay_r != 15'h0000);
      dly_sec_r <= delay_r;
      dly_cyc_r <= 32'h0000_0000;
    end else if (entered && off_hit) begin
      status_r  <= 1'b0;
      pend_r    <= 1'b0;
    end else if (pend_r) begin
      if (dly_sec_r == 15'h0000) begin
        status_r <= 1'b1;
        pend_r   <= 1'b0;
      end else if (dly_cyc_r == SEC_CYC - 32'h0000_0001) begin
        dly_cyc_r <= 32'h0000_0000;
        dly_sec_r <= dly_sec_r - 15'h0001;
      end else begin
        dly_cyc_r <= dly_cyc_r + 32'h0000_0001;
      end
    end
  end

  // Enable only gates the pin, so stored settings and tracking carry on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_pin_r <= 1'b0;
    end else begin
      status_pin_r <= status_r && cfg_r.status_en;
    end
  end

  // Open collector: the low level is driven only while on
  assign status_oc_o        = 1'b0;
  assign status_oc_oe       = status_pin_r;
  assign status_annunciator = status_pin_r;

  a_annunciator_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    status_annunciator == status_oc_oe)
    else $error("annunciator disagrees with status output");

  a_on_no_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    entered && on_hit && delay_r == 15'h0000 && cfg_r.status_en
      ##1 cfg_r.status_en |=> status_oc_oe)
    else $error("status output missed its turn-on entry");

  a_off_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    entered && off_hit && !on_hit |=> !status_r ##1 !status_oc_oe)
    else $error("status output missed its turn-off entry");

  a_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_r.status_en |=> !status_oc_oe)
    else $error("disabled status output still driven");

  a_delay_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    pend_r && dly_sec_r != 15'h0000 && !entered |=> !$rose(status_r))
    else $error("status output turned on before its delay");

  // -------------------------------------------------------------------------
  // AXI4-Lite write path
  // -------------------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_go         = aw_held_r && w_held_r && !bvalid_r;
  assign ctrl_word     = {20'h00000, cfg_r};
  assign delay_word    = {17'h00000, delay_r};
  assign wr_ctrl       = merge(ctrl_word, w_data_r, w_strb_r);
  assign wr_delay      = merge(delay_word, w_data_r, w_strb_r);

  // Address and data are taken in either order; response once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= reset_status_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        if (aw_addr_r[7:2] == reset_status_pkg::CTRL_OFF[7:2] ||
            aw_addr_r[7:2] == reset_status_pkg::DELAY_OFF[7:2] ||
            aw_addr_r[7:2] == reset_status_pkg::STATUS_OFF[7:2] ||
            aw_addr_r[7:2] == reset_status_pkg::TOTAL_OFF[7:2]) begin
          bresp_r <= reset_status_pkg::RESP_OKAY;
        end else begin
          bresp_r <= reset_status_pkg::RESP_SLVERR;
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Writable settings; an oversized delay is clamped to the longest allowed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r   <= reset_status_pkg::cfg_t'(reset_status_pkg::CTRL_RST);
      delay_r <= reset_status_pkg::DELAY_RST;
    end else if (wr_go) begin
      if (aw_addr_r[7:2] == reset_status_pkg::CTRL_OFF[7:2]) begin
        cfg_r <= reset_status_pkg::cfg_t'(wr_ctrl[11:0]);
      end else if (aw_addr_r[7:2] == reset_status_pkg::DELAY_OFF[7:2]) begin
        if (wr_delay[31:15] != 17'h00000 ||
            wr_delay[14:0] > reset_status_pkg::STATUS_DELAY_MAX_S) begin
          delay_r <= reset_status_pkg::STATUS_DELAY_MAX_S;
        end else begin
          delay_r <= wr_delay[14:0];
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // AXI4-Lite read path
  // -------------------------------------------------------------------------
  assign stat_w = '{grand_total_view: gt_view_r, ext_closed: ext_level,
                    on_pending: pend_r, pin_on: status_pin_r, status_on: status_r};
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Read decode; unmapped words read zero with an error response
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = reset_status_pkg::RESP_OKAY;
    if (s_axi_araddr[7:2] == reset_status_pkg::CTRL_OFF[7:2]) begin
      rdata_nxt = ctrl_word;
    end else if (s_axi_araddr[7:2] == reset_status_pkg::DELAY_OFF[7:2]) begin
      rdata_nxt = delay_word;
    end else if (s_axi_araddr[7:2] == reset_status_pkg::STATUS_OFF[7:2]) begin
      rdata_nxt = {27'h0000000, stat_w};
    end else if (s_axi_araddr[7:2] == reset_status_pkg::TOTAL_OFF[7:2]) begin
      rdata_nxt = grand_total_r;
    end else begin
      rresp_nxt = reset_status_pkg::RESP_SLVERR;
    end
  end

  // Answer one cycle after the address is taken, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= reset_status_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : reset_status_ctrl

// File: logic/reset_status_pkg.sv
// Constants, types and function summary for the timer reset and status output block
// Function
// - With local reset enabled, reset timer after reset pair held over three seconds in display mode.
// - Accumulate timer run time as grand total, viewable by pressing two buttons in display mode.
// - With clear enabled, zero grand total after view pair held over ten seconds in display mode.
// - Reset the timer when the external reset terminals stay joined long enough.
// - Slow external setting needs the contact closed for one second.
// - Fast external setting needs the contact closed for 2 ms.
// - Light the status annunciator whenever the status output is on.
// - Status output turns on at the on state entry, off at the off state entry.
// - Turn-on state selectable from reset, running, paused, restart delay, complete.
// - Turn-off state selectable from the same five timer states.
// - Inverted turn-on fires on entry into any state but the named one.
// - Inverted turn-off fires on entry into any state but the named one.
// - On at running, off at inverted running keeps output on only while running.
// - Enable bit gates the output without altering stored on, off or delay settings.
// - Optional turn-on delay in one-second steps from zero to 32,400 seconds.
package reset_status_pkg;

  // -------------------------------------------------------------------------
  // Clock and hold times
  // -------------------------------------------------------------------------
  localparam logic [31:0] CLK_HZ              = 32'd50_000_000;
  localparam logic [31:0] LOCAL_RESET_HOLD_S  = 32'd3;
  localparam logic [31:0] GRAND_CLEAR_HOLD_S  = 32'd10;
  localparam logic [31:0] EXT_SLOW_HOLD_S     = 32'd1;
  localparam logic [31:0] EXT_FAST_HOLD_MS    = 32'd2;
  localparam logic [31:0] SECOND_CYC          = CLK_HZ;
  localparam logic [31:0] LOCAL_RESET_CYC     = LOCAL_RESET_HOLD_S * CLK_HZ;
  localparam logic [31:0] GRAND_CLEAR_CYC     = GRAND_CLEAR_HOLD_S * CLK_HZ;
  localparam logic [31:0] EXT_SLOW_CYC        = EXT_SLOW_HOLD_S * CLK_HZ;
  localparam logic [31:0] EXT_FAST_CYC        = EXT_FAST_HOLD_MS * (CLK_HZ / 32'd1000);
  localparam logic [14:0] STATUS_DELAY_MAX_S  = 15'd32400;

  // -------------------------------------------------------------------------
  // Register map, byte addresses
  // -------------------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  CTRL_OFF    = 8'h00;
  localparam logic [7:0]  DELAY_OFF   = 8'h04;
  localparam logic [7:0]  STATUS_OFF  = 8'h08;
  localparam logic [7:0]  TOTAL_OFF   = 8'h0C;
  localparam logic [11:0] CTRL_RST    = 12'h000;
  localparam logic [14:0] DELAY_RST   = 15'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // Timer states reported by the timer core
  typedef enum logic [2:0] {
    ST_RESET       = 3'b000,
    ST_RUN         = 3'b001,
    ST_PAUSED      = 3'b010,
    ST_RESTART_DLY = 3'b011,
    ST_DONE        = 3'b100
  } timer_state_t;

  // Control register layout, bit 0 is the last field
  typedef struct packed {
    logic         off_inv;
    timer_state_t off_state;
    logic         on_inv;
    timer_state_t on_state;
    logic         status_en;
    logic         quick_reset_qualify;
    logic         grand_total_clear_enable;
    logic         local_timer_reset_enable;
  } cfg_t;

  // Status register layout
  typedef struct packed {
    logic grand_total_view;
    logic ext_closed;
    logic on_pending;
    logic pin_on;
    logic status_on;
  } stat_t;

endpackage : reset_status_pkg

// File: testbench/ext_party.sv
// Far side model: reset contact and pulled-up status line
module ext_party (
  // Clock and status drive
  input  wire logic aclk,
  input  wire logic oc_o,
  input  wire logic oc_oe,
  // Contact and line level
  output logic      closed,
  output wire logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up sets the level whenever the collector is off
  assign pin = oc_oe ? oc_o : 1'b1;
  // Contact shut for n cycles, then left open so the filter settles
  task automatic close(input int n);
    closed <= 1'b1;
    repeat (n) @(posedge aclk);
    closed <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : close
  initial closed = 1'b0;
endmodule : ext_party

// File: testbench/tb_timer_reset_and_status_output.sv
// Self-checking bench for the reset and status output block
module tb_timer_reset_and_status_output;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, dmode = 1'b0;
  logic        awr, wrd, bv, arr, rv, trst, oc, oe, ann, gtv, closed, pin;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rdv, t0;
  logic [1:0]  resp, bresp, rresp;
  logic [3:0]  btn = 4'h0, ws = 4'hF;
  reset_status_pkg::timer_state_t ts = reset_status_pkg::ST_RESET;
  int          err_total = 0, checked = 0, pulses = 0;
  always #10 aclk = ~aclk;
  // Each timer reset pulse is counted, so a double fire shows up
  always @(posedge aclk) if (trst === 1'b1) pulses++;
  reset_status_ctrl #(.LOC_HOLD_CYC(32'h1E), .GT_HOLD_CYC(32'h64), .EXT_SLOW_CYC(32'h14),
    .EXT_FAST_CYC(32'h4), .SEC_CYC(32'hA)) i_reset_status_ctrl (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdv), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .timer_state(ts), .display_mode(dmode),
    .timer_reset(trst), .panel_btn(btn), .ext_reset_closed(closed), .status_oc_o(oc),
    .status_oc_oe(oe), .status_annunciator(ann), .grand_total_view(gtv));
  ext_party i_ext_party (.aclk(aclk), .oc_o(oc), .oc_oe(oe), .closed(closed), .pin(pin));
  // Verdict and end of run
  task automatic end_of_test;
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Bus cycles: valid held until taken, ready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    // No local limit: only the watchdog may end a stuck wait
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    resp = bresp;
    br <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rdat = rdv;
    resp = rresp;
    rr <= 1'b0;
  endtask : rd
  // Enter a timer state; a negative e skips the check
  task automatic go(input int s, input int e);
    ts <= reset_status_pkg::timer_state_t'(s);
    repeat (4) @(posedge aclk);
    if (e >= 0) begin
      chk("status", e, 32'(oe));
      chk("annunciator", e, 32'(ann));
      chk("pin", 1 - e, 32'(pin));
    end
  endtask : go
  task automatic hold(input logic [3:0] v, input int n);
    btn <= v;
    repeat (n) @(posedge aclk);
    btn <= 4'h0;
    repeat (6) @(posedge aclk);
  endtask : hold
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_of_test();
  end
  initial begin
    int s;
    void'($urandom(32'h0A4C));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    wr(8'h40, 32'h0000_0000);
    chk("wrerr", 32'(reset_status_pkg::RESP_SLVERR), 32'(resp));
    rd(8'h40);
    chk("unmapped", 32'(reset_status_pkg::RESP_SLVERR), 32'(resp));
    for (int i = 0; i < 10; i++) begin
      s = i % 5;
      wr(8'h00, 32'h8 | (s << 4) | (s << 8) | (i < 5 ? 32'h800 : 32'h80));
      go(i < 5 ? (s + 1) % 5 : s, i < 5 ? -1 : 0);
      go(i < 5 ? s : (s + 1) % 5, 1);
      go(i < 5 ? (s + 2) % 5 : s, 0);
    end
    wr(8'h00, 32'h918);
    go(1, 1);
    wr(8'h00, 32'h910);
    repeat (3) @(posedge aclk);
    chk("gated", 32'h0, 32'(oe));
    rd(8'h00);
    chk("ctrl", 32'h910, rdat);
    // Only the low lane is strobed, so the upper settings must survive
    ws <= 4'h1;
    wr(8'h00, 32'hFFFF_FF18);
    ws <= 4'hF;
    rd(8'h00);
    chk("strobe", 32'h918, rdat);
    repeat (3) @(posedge aclk);
    chk("regated", 32'h1, 32'(oe));
    go(2, 0);
    wr(8'h04, 32'h2);
    chk("okay", 32'(reset_status_pkg::RESP_OKAY), 32'(resp));
    ts <= reset_status_pkg::ST_RUN;
    repeat (23) @(posedge aclk);
    chk("early", 32'h0, 32'(oe));
    repeat (1) @(posedge aclk);
    chk("delayed", 32'h1, 32'(oe));
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04);
    chk("clamp", 32'h7E90, rdat);
    go(2, -1);
    rd(8'h0C);
    t0 = rdat;
    go(1, -1);
    repeat (41) @(posedge aclk);
    go(2, -1);
    rd(8'h0C);
    chk("total", 32'h1, 32'((rdat - t0) inside {4, 5}));
    wr(8'h00, 32'h2);
    dmode <= 1'b1;
    btn <= 4'hC;
    repeat (8) @(posedge aclk);
    chk("view", 32'h1, 32'(gtv));
    hold(4'hC, 105);
    rd(8'h0C);
    chk("cleared", 32'h0, rdat);
    wr(8'h00, 32'h4);
    repeat (3) i_ext_party.close(int'($urandom_range(4, 1)));
    i_ext_party.close(12);
    chk("fast", 32'h1, 32'(pulses));
    wr(8'h00, 32'h0);
    i_ext_party.close(14);
    i_ext_party.close(28);
    chk("slow", 32'h2, 32'(pulses));
    wr(8'h00, 32'h1);
    hold(4'h3, 20);
    hold(4'h3, 40);
    chk("local", 32'h3, 32'(pulses));
    end_of_test();
  end
endmodule : tb_timer_reset_and_status_output
